// >>> logic/pin_irq_detect.sv
// Purpose: Edge or level interrupt detector for one input.
// Assumes: The level is synchronous to the clock.
// Notes:   Level modes fire every cycle while the level holds.
`timescale 1ns/1ps
`default_nettype none
module pin_irq_detect import pinmux_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Detection
  input wire logic i_level,
  input wire logic [2:0] i_mode,
  output logic o_event
);
  logic prev_q;
  logic rise;
  logic fall;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= i_level;
    end
  end

  assign rise = i_level && !prev_q;
  assign fall = !i_level && prev_q;
  assign o_event = (i_mode == IRQ_RISE && rise) || (i_mode == IRQ_FALL && fall) ||
                   (i_mode == IRQ_BOTH && (rise || fall)) || (i_mode == IRQ_HIGH && i_level) ||
                   (i_mode == IRQ_LOW && !i_level);
endmodule
`default_nettype wire

// >>> logic/pin_mux_top.sv
// Purpose: Pad multiplexer with low-leakage cell control and wake interrupts.
// Assumes: APB slave with no wait states; pads synchronous to I_MCLK.
// Notes:   Pad drive freezes while I_LOW_POWER is high.
//
// Contract
// R1 - twelve pads, one function each
// R2 - forty cell configs, twenty-three bonded
// R3 - dedicated functions take their pads
// R4 - unassigned cells reset to hi-Z
// R5 - losing cells on a pad stay off
// R6 - slow oscillator pad wired directly
// R7 - each cell selects its function
// R8 - directions: off, input, output
// R9 - pulls on input-enabled cells
// R10 - outputs hold in low-power modes
// R11 - rise, fall, both or level interrupts
// R12 - interrupts optionally wake the system
// R13 - wake signals both ways
// R14 - chip-select input, slave only
// R15 - cell two data out master only
// R16 - device drives host wake pad
// R17 - host drives device wake pad
// R18 - fixed priority on pad conflicts
// R19 - per-cell writable configuration storage
`timescale 1ns/1ps
`default_nettype none
module pin_mux_top import pinmux_pkg::*; (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Pads
  input wire logic [NUM_PADS-1:0] I_PAD_IN,
  output logic [NUM_PADS-1:0] O_PAD_OUT,
  output logic [NUM_PADS-1:0] O_PAD_OE,
  output logic [NUM_PADS-1:0] O_PAD_PULL_UP,
  output logic [NUM_PADS-1:0] O_PAD_PULL_DN,
  // Multiplexed peripheral functions
  input wire logic [NUM_CELLS*ALT_OUTS-1:0] I_ALT_OUT,
  output logic [NUM_CELLS-1:0] O_CELL_IN,
  input wire logic I_AUX_SPORT_SLAVE,
  output logic O_AUX_SPORT_SELECT,
  // Dedicated functions
  input wire logic I_AUDIO_DOUT,
  input wire logic I_AUDIO_CLK,
  input wire logic I_AUDIO_SYNC,
  output logic O_AUDIO_DIN,
  input wire logic I_SHARED_CLOCK_REQUEST,
  output logic O_DEVICE_WAKE_IN,
  output logic O_EXT_SLOW_OSC_IN,
  // Power and interrupt
  input wire logic I_LOW_POWER,
  output logic O_IRQ,
  output logic O_SYS_WAKE
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [CFG_W-1:0] cfg_q [NUM_CELLS];
  logic [NUM_CELLS-1:0] dout_q;
  logic [DED_W-1:0] ded_q;
  logic [EV_W-1:0] stat_q;
  logic [EV_W-1:0] en_q;
  logic [NUM_PADS-1:0] pad_out_q;
  logic [NUM_PADS-1:0] pad_oe_q;
  logic [NUM_PADS-1:0] pull_up_q;
  logic [NUM_PADS-1:0] pull_dn_q;
  logic [NUM_CELLS-1:0] cell_in_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic dev_wake_q;
  logic audio_din_q;
  logic select_q;

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  logic setup;
  logic wr;
  logic is_cfg;
  logic hit;
  logic [5:0] cfg_idx;
  logic [31:0] rmux;
  logic [EV_W-1:0] clr;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] wake_mask;

  assign setup = I_PSEL && !I_PENABLE;
  assign wr = I_PSEL && I_PENABLE && I_PWRITE;
  assign cfg_idx = I_PADDR[7:2];
  assign is_cfg = I_PADDR <= A_CFG_LAST;
  assign hit = is_cfg || (I_PADDR >= A_DOUT_LO && I_PADDR <= A_EN_HI && I_PADDR[1:0] == 2'h0);
  assign rmux = is_cfg ? 32'(cfg_q[cfg_idx]) :
                I_PADDR == A_DOUT_LO ? dout_q[31:0] :
                I_PADDR == A_DOUT_HI ? 32'(dout_q[NUM_CELLS-1:32]) :
                I_PADDR == A_PAD_IN ? 32'(I_PAD_IN) :
                I_PADDR == A_DED ? 32'(ded_q) :
                I_PADDR == A_STAT_LO ? stat_q[31:0] :
                I_PADDR == A_STAT_HI ? 32'(stat_q[EV_W-1:32]) :
                I_PADDR == A_EN_LO ? en_q[31:0] :
                I_PADDR == A_EN_HI ? 32'(en_q[EV_W-1:32]) : 32'h0;
  assign clr = !wr ? '0 :
               I_PADDR == A_CLR_LO ? EV_W'(I_PWDATA) :
               I_PADDR == A_CLR_HI ? {I_PWDATA[EV_W-33:0], 32'h0} : '0;

  assign O_PREADY = 1'b1;
  assign O_PRDATA = rdata_q;
  assign O_PSLVERR = I_PSEL && I_PENABLE && err_q;

  // Read data is caught in the setup cycle so the bus sees a flop output.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_q <= 32'h0;
      err_q <= 1'b0;
    end else if (setup) begin
      rdata_q <= I_PWRITE ? 32'h0 : rmux;
      err_q <= !hit;
    end
  end

  // Unmapped writes are dropped; clear and status words are not stored.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      for (int c = 0; c < NUM_CELLS; c++) cfg_q[c] <= '0; // R4
      dout_q <= '0;
      ded_q <= '0;
      en_q <= '0;
    end else if (wr) begin
      if (is_cfg) cfg_q[cfg_idx] <= I_PWDATA[CFG_W-1:0]; // R19
      if (I_PADDR == A_DOUT_LO) dout_q[31:0] <= I_PWDATA;
      if (I_PADDR == A_DOUT_HI) dout_q[NUM_CELLS-1:32] <= I_PWDATA[NUM_CELLS-33:0];
      if (I_PADDR == A_DED) ded_q <= I_PWDATA[DED_W-1:0];
      if (I_PADDR == A_EN_LO) en_q[31:0] <= I_PWDATA;
      if (I_PADDR == A_EN_HI) en_q[EV_W-1:32] <= I_PWDATA[EV_W-33:0];
    end
  end

  // ------------------------------------------------------------------
  // Dedicated pad owners
  // ------------------------------------------------------------------
  logic [NUM_PADS-1:0] ded_active;
  logic [NUM_PADS-1:0] ded_oe;
  logic [NUM_PADS-1:0] ded_out;

  for (genvar p = 0; p < NUM_PADS; p++) begin : g_ded
    if (PAD_DED[p] == DED_NA) begin : g_none
      assign ded_active[p] = 1'b0;
      assign ded_oe[p] = 1'b0;
      assign ded_out[p] = 1'b0;
    end else begin : g_own
      assign ded_active[p] = ded_q[PAD_DED[p]]; // R3
      assign ded_oe[p] = (PAD_DED[p] == DED_AUDIO && p != PAD_C7) || PAD_DED[p] == DED_CLKREQ ||
                         PAD_DED[p] == DED_HOSTWAKE;
      assign ded_out[p] = PAD_DED[p] == DED_HOSTWAKE ? ded_q[DED_HOST_LEVEL] : // R16
                          PAD_DED[p] == DED_CLKREQ ? I_SHARED_CLOCK_REQUEST :
                          p == PAD_A8 ? I_AUDIO_DOUT :
                          p == PAD_B7 ? I_AUDIO_CLK : I_AUDIO_SYNC;
    end
  end

  // ------------------------------------------------------------------
  // Cells: function, direction, arbitration, interrupts
  // ------------------------------------------------------------------
  logic [NUM_CELLS-1:0] req;
  logic [NUM_CELLS-1:0] grant;
  logic [NUM_CELLS-1:0] cell_oe;
  logic [NUM_CELLS-1:0] cell_ie;
  logic [NUM_CELLS-1:0] cell_dout;
  logic [NUM_CELLS-1:0] cell_pin;
  logic [NUM_CELLS-1:0] cell_pu;
  logic [NUM_CELLS-1:0] cell_pd;
  logic [NUM_CELLS-1:0] sel_in;
  logic [EXT_W-1:0] req_x;

  assign req_x = EXT_W'(req);

  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
    localparam logic [3:0] P = pad_of(c);
    localparam int S = slot_of(c);
    logic [2:0] fn;
    logic [1:0] dir;
    logic [1:0] pull;
    logic want_in;
    logic want_out;
    logic legal;

    assign fn = cfg_q[c][CFG_FN_LSB +: 3];
    assign dir = cfg_q[c][CFG_DIR_LSB +: 2];
    assign pull = cfg_q[c][CFG_PULL_LSB +: 2];
    // General purpose takes its direction field; other functions fix theirs unless it is off.
    assign want_in = fn == FN_GPIO ? dir == DIR_IN : (dir != DIR_OFF && fn < FN_OUT_A); // R7 R8
    assign want_out = fn == FN_GPIO ? dir == DIR_OUT : (dir != DIR_OFF && fn >= FN_OUT_A); // R7 R8
    assign legal = !(fn == FN_SEL && !I_AUX_SPORT_SLAVE) && // R14
                   !(fn == FN_DOUT_M && I_AUX_SPORT_SLAVE); // R15
    assign req[c] = (want_in || want_out) && legal;
    if (P == PAD_NONE) begin : g_unbonded
      assign grant[c] = 1'b0; // R2
      assign cell_pin[c] = 1'b0;
    end else begin : g_bonded
      assign grant[c] = req[c] && !ded_active[P] && !(S > 0 && req_x[PAD_CELL[P][0]]) && // R5 R18 R3
                        !(S > 1 && req_x[PAD_CELL[P][1]]); // R1
      assign cell_pin[c] = I_PAD_IN[P];
    end
    assign cell_oe[c] = grant[c] && want_out;
    assign cell_ie[c] = grant[c] && want_in;
    assign cell_dout[c] = fn == FN_GPIO ? dout_q[c] : I_ALT_OUT[c*ALT_OUTS + int'(fn[1:0])];
    assign cell_pu[c] = cell_ie[c] && pull == PULL_UP; // R9
    assign cell_pd[c] = cell_ie[c] && pull == PULL_DN; // R9
    assign sel_in[c] = cell_ie[c] && fn == FN_SEL; // R14
    assign wake_mask[c] = cfg_q[c][CFG_WAKE_BIT];

    pin_irq_detect u_irq (
      .i_clk(I_MCLK),
      .i_rst(I_RST),
      .i_level(cell_ie[c] && cell_pin[c]),
      .i_mode(cfg_q[c][CFG_IRQ_LSB +: 3]),
      .o_event(ev[c])
    ); // R11
  end

  pin_irq_detect u_dev_wake (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_level(ded_q[DED_DEVWAKE] && I_PAD_IN[PAD_F8]),
    .i_mode(IRQ_RISE),
    .o_event(ev[EV_DEV_WAKE])
  ); // R13 R17
  assign wake_mask[EV_DEV_WAKE] = 1'b1; // R13

  // ------------------------------------------------------------------
  // Pad resolution
  // ------------------------------------------------------------------
  logic [NUM_PADS-1:0] pad_oe_d;
  logic [NUM_PADS-1:0] pad_out_d;
  logic [NUM_PADS-1:0] pu_d;
  logic [NUM_PADS-1:0] pd_d;
  logic [EXT_W-1:0] oe_x;
  logic [EXT_W-1:0] drv_x;
  logic [EXT_W-1:0] pu_x;
  logic [EXT_W-1:0] pd_x;

  assign oe_x = EXT_W'(cell_oe);
  assign drv_x = EXT_W'(cell_oe & cell_dout);
  assign pu_x = EXT_W'(cell_pu);
  assign pd_x = EXT_W'(cell_pd);

  for (genvar p = 0; p < NUM_PADS; p++) begin : g_pad
    logic c_oe;
    logic c_out;
    assign c_oe = oe_x[PAD_CELL[p][0]] || oe_x[PAD_CELL[p][1]] || oe_x[PAD_CELL[p][2]];
    assign c_out = drv_x[PAD_CELL[p][0]] || drv_x[PAD_CELL[p][1]] || drv_x[PAD_CELL[p][2]];
    assign pad_oe_d[p] = ded_active[p] ? ded_oe[p] : c_oe;
    assign pad_out_d[p] = ded_active[p] ? ded_out[p] : c_out;
    assign pu_d[p] = !ded_active[p] && (pu_x[PAD_CELL[p][0]] || pu_x[PAD_CELL[p][1]] || pu_x[PAD_CELL[p][2]]);
    assign pd_d[p] = !ded_active[p] && (pd_x[PAD_CELL[p][0]] || pd_x[PAD_CELL[p][1]] || pd_x[PAD_CELL[p][2]]);
  end

  // Frozen in low power so sleeping logic cannot glitch a driven pad.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      pad_oe_q <= '0;
      pad_out_q <= '0;
      pull_up_q <= '0;
      pull_dn_q <= '0;
    end else if (!I_LOW_POWER) begin // R10
      pad_oe_q <= pad_oe_d;
      pad_out_q <= pad_out_d;
      pull_up_q <= pu_d;
      pull_dn_q <= pd_d;
    end
  end

  assign O_PAD_OE = pad_oe_q;
  assign O_PAD_OUT = pad_out_q;
  assign O_PAD_PULL_UP = pull_up_q;
  assign O_PAD_PULL_DN = pull_dn_q;

  // ------------------------------------------------------------------
  // Inputs to the core, interrupts and wake
  // ------------------------------------------------------------------
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      cell_in_q <= '0;
      dev_wake_q <= 1'b0;
      audio_din_q <= 1'b0;
      select_q <= 1'b1;
      stat_q <= '0;
    end else begin
      cell_in_q <= cell_ie & cell_pin;
      dev_wake_q <= ded_q[DED_DEVWAKE] && I_PAD_IN[PAD_F8]; // R17
      audio_din_q <= ded_q[DED_AUDIO] && I_PAD_IN[PAD_C7];
      select_q <= !(|sel_in) || |(sel_in & cell_pin); // R14
      stat_q <= (stat_q & ~clr) | ev; // R11
    end
  end

  assign O_CELL_IN = cell_in_q;
  assign O_DEVICE_WAKE_IN = dev_wake_q;
  assign O_AUDIO_DIN = audio_din_q;
  assign O_AUX_SPORT_SELECT = select_q;
  // Oscillator passes unclocked: sampling would alias it to I_MCLK.
  assign O_EXT_SLOW_OSC_IN = ded_q[DED_SLOWOSC] && I_PAD_IN[PAD_D6]; // R6
  assign O_IRQ = |(stat_q & en_q);
  assign O_SYS_WAKE = |(stat_q & en_q & wake_mask); // R12

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_one_driver;
    @(posedge I_MCLK) disable iff (I_RST)
    $onehot0({cell_oe[3], cell_oe[29], cell_oe[35]}) && $onehot0({cell_oe[2], cell_oe[28], cell_oe[37]});
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("two cells drive one pad"); // R1

  property p_ded_blocks;
    @(posedge I_MCLK) disable iff (I_RST)
    ded_q[DED_SLOWOSC] |-> !grant[6] && !grant[31];
  endproperty
  a_ded_blocks: assert property (p_ded_blocks) else $error("dedicated pad still muxed"); // R3

  property p_reset_hiz;
    @(posedge I_MCLK) disable iff (I_RST)
    $fell(I_RST) |-> O_PAD_OE == '0;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("pad driven after reset"); // R4

  property p_priority;
    @(posedge I_MCLK) disable iff (I_RST)
    req[3] && !ded_active[PAD_A8] |-> grant[3] && !grant[29] && !grant[35];
  endproperty
  a_priority: assert property (p_priority) else $error("priority winner wrong"); // R5 R18

  property p_osc;
    @(posedge I_MCLK) disable iff (I_RST)
    ded_q[DED_SLOWOSC] |-> O_EXT_SLOW_OSC_IN == I_PAD_IN[PAD_D6];
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator path broken"); // R6

  property p_hold;
    @(posedge I_MCLK) disable iff (I_RST)
    I_LOW_POWER ##1 I_LOW_POWER |-> $stable(O_PAD_OE) && $stable(O_PAD_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("pad changed in low power"); // R10

  property p_gpio_out;
    @(posedge I_MCLK) disable iff (I_RST)
    !I_LOW_POWER && !ded_q[DED_AUDIO] && grant[0] && cell_oe[0] |=> O_PAD_OE[7] && O_PAD_OUT[7] == $past(cell_dout[0]);
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("cell output not on pad"); // R7 R8

  property p_rise;
    @(posedge I_MCLK) disable iff (I_RST)
    cfg_q[12][CFG_IRQ_LSB +: 3] == IRQ_RISE && cell_ie[12] && I_PAD_IN[PAD_C7] &&
    $past(!(cell_ie[12] && I_PAD_IN[PAD_C7])) |=> stat_q[12];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge not latched"); // R11

  property p_wake;
    @(posedge I_MCLK) disable iff (I_RST)
    stat_q[EV_DEV_WAKE] && en_q[EV_DEV_WAKE] |-> O_SYS_WAKE && O_IRQ;
  endproperty
  a_wake: assert property (p_wake) else $error("device wake lost"); // R12 R13

  property p_sel_slave;
    @(posedge I_MCLK) disable iff (I_RST)
    !I_AUX_SPORT_SLAVE |-> sel_in == '0 ##1 O_AUX_SPORT_SELECT;
  endproperty
  a_sel_slave: assert property (p_sel_slave) else $error("select used as master"); // R14

  property p_mout;
    @(posedge I_MCLK) disable iff (I_RST)
    I_AUX_SPORT_SLAVE && cfg_q[2][CFG_FN_LSB +: 3] == FN_DOUT_M |-> !grant[2];
  endproperty
  a_mout: assert property (p_mout) else $error("master data out in slave"); // R15

  property p_host_wake;
    @(posedge I_MCLK) disable iff (I_RST)
    ded_q[DED_HOSTWAKE] && !I_LOW_POWER |=> O_PAD_OE[9] && O_PAD_OUT[9] == $past(ded_q[DED_HOST_LEVEL]);
  endproperty
  a_host_wake: assert property (p_host_wake) else $error("host wake not driven"); // R16

endmodule
`default_nettype wire

// >>> logic/pinmux_pkg.sv
// Purpose: Shared constants for the low-leakage pad multiplexer.
// Assumes: 32-bit register words on byte addresses.
// Notes:   Pad and cell maps are constant tables, not storage.
`default_nettype none
package pinmux_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int NUM_PADS = 12;
  localparam int NUM_CELLS = 40;
  localparam int SLOTS = 3;
  localparam int ALT_OUTS = 4;
  localparam int EXT_W = 64;
  localparam int EV_W = 41;
  localparam int EV_DEV_WAKE = 40;
  localparam logic [5:0] NO_CELL = 6'h3f;
  localparam logic [3:0] PAD_NONE = 4'hf;

  // ------------------------------------------------------------------
  // Pads and the cells bonded to each, highest priority first
  // ------------------------------------------------------------------
  localparam int PAD_A8 = 0;
  localparam int PAD_B7 = 3;
  localparam int PAD_C7 = 6;
  localparam int PAD_D6 = 8;
  localparam int PAD_F8 = 10;
  localparam logic [5:0] PAD_CELL [NUM_PADS][SLOTS] = '{
    '{6'h03, 6'h1d, 6'h23}, '{6'h0f, NO_CELL, NO_CELL},
    '{6'h0b, 6'h1a, NO_CELL}, '{6'h02, 6'h1c, 6'h25},
    '{6'h1b, 6'h21, NO_CELL}, '{6'h1e, NO_CELL, NO_CELL},
    '{6'h0c, NO_CELL, NO_CELL}, '{6'h00, 6'h22, NO_CELL},
    '{6'h06, 6'h1f, NO_CELL}, '{6'h19, 6'h20, NO_CELL},
    '{6'h24, 6'h26, NO_CELL}, '{6'h04, 6'h18, NO_CELL}};

  // ------------------------------------------------------------------
  // Dedicated functions: enable bit index, and owner of each pad
  // ------------------------------------------------------------------
  localparam int DED_AUDIO = 0;
  localparam int DED_CLKREQ = 1;
  localparam int DED_DEVWAKE = 2;
  localparam int DED_HOSTWAKE = 3;
  localparam int DED_SLOWOSC = 4;
  localparam int DED_HOST_LEVEL = 5;
  localparam int DED_W = 6;
  localparam int DED_NA = 7;
  localparam int PAD_DED [NUM_PADS] = '{DED_AUDIO, DED_NA, DED_NA, DED_AUDIO, DED_NA, DED_NA,
    DED_AUDIO, DED_AUDIO, DED_SLOWOSC, DED_HOSTWAKE, DED_DEVWAKE, DED_CLKREQ};

  // ------------------------------------------------------------------
  // Cell configuration word
  // ------------------------------------------------------------------
  localparam int CFG_W = 11;
  localparam int CFG_FN_LSB = 0;
  localparam int CFG_DIR_LSB = 3;
  localparam int CFG_PULL_LSB = 5;
  localparam int CFG_IRQ_LSB = 7;
  localparam int CFG_WAKE_BIT = 10;
  localparam logic [2:0] FN_GPIO = 3'h0;
  localparam logic [2:0] FN_SEL = 3'h3;
  localparam logic [2:0] FN_OUT_A = 3'h4;
  localparam logic [2:0] FN_DOUT_M = 3'h7;
  localparam logic [1:0] DIR_OFF = 2'h0;
  localparam logic [1:0] DIR_IN = 2'h1;
  localparam logic [1:0] DIR_OUT = 2'h2;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DN = 2'h2;
  localparam logic [2:0] IRQ_RISE = 3'h1;
  localparam logic [2:0] IRQ_FALL = 3'h2;
  localparam logic [2:0] IRQ_BOTH = 3'h3;
  localparam logic [2:0] IRQ_HIGH = 3'h4;
  localparam logic [2:0] IRQ_LOW = 3'h5;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [11:0] A_CFG_LAST = 12'h09c;
  localparam logic [11:0] A_DOUT_LO = 12'h100;
  localparam logic [11:0] A_DOUT_HI = 12'h104;
  localparam logic [11:0] A_PAD_IN = 12'h108;
  localparam logic [11:0] A_DED = 12'h10c;
  localparam logic [11:0] A_STAT_LO = 12'h110;
  localparam logic [11:0] A_STAT_HI = 12'h114;
  localparam logic [11:0] A_CLR_LO = 12'h118;
  localparam logic [11:0] A_CLR_HI = 12'h11c;
  localparam logic [11:0] A_EN_LO = 12'h120;
  localparam logic [11:0] A_EN_HI = 12'h124;

  function automatic logic [3:0] pad_of(int c);
    for (int p = 0; p < NUM_PADS; p++) begin
      for (int s = 0; s < SLOTS; s++) begin
        if (PAD_CELL[p][s] == 6'(c)) return 4'(p);
      end
    end
    return PAD_NONE;
  endfunction

  function automatic int slot_of(int c);
    for (int p = 0; p < NUM_PADS; p++) begin
      for (int s = 0; s < SLOTS; s++) begin
        if (PAD_CELL[p][s] == 6'(c)) return s;
      end
    end
    return 0;
  endfunction

endpackage
`default_nettype wire

// >>> testbench/low_leakage_io_pin_mux_tb.sv
// Purpose: Self-checking bench for the pad multiplexer.
// Assumes: Stimulus moves on rising edges, checks sit on falling edges.
// Notes:   Row table covers plain cell settings; the rest is hand-written.
`timescale 1ns/1ps
`default_nettype none
module low_leakage_io_pin_mux_tb import pinmux_pkg::*; ;
  typedef struct packed {logic [5:0] c; logic [10:0] cfg; logic [3:0] p; logic [3:0] e;} row_t;
  row_t rows [9] = '{'{6'd0, 11'h010, 4'd7, 4'hc}, '{6'd0, 11'h028, 4'd7, 4'h2},
    '{6'd0, 11'h048, 4'd7, 4'h1}, '{6'd0, 11'h000, 4'd7, 4'h0}, '{6'd3, 11'h010, 4'd0, 4'hc},
    '{6'd4, 11'h014, 4'd11, 4'hc}, '{6'd4, 11'h015, 4'd11, 4'h8}, '{6'd24, 11'h016, 4'd11, 4'hc},
    '{6'd29, 11'h010, 4'd0, 4'h8}};
  logic [2:0] md [5] = '{IRQ_RISE, IRQ_FALL, IRQ_BOTH, IRQ_HIGH, IRQ_LOW};
  logic [4:0] st = 5'h16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pw = 1'b0, lp = 1'b0, slv = 1'b0;
  logic [11:0] pa = 12'h0;
  logic [31:0] pwd = 32'h0, rd, prd;
  logic er, prdy, perr, sel, adin, dwake, sosc, irq, swake;
  logic [3:0] ded = 4'h0;
  logic [NUM_PADS-1:0] pin, pout, poe, pu, pd;
  logic [NUM_PADS-1:0] xv = 12'h0, xe = 12'h0;
  logic [NUM_CELLS-1:0] cin;
  logic [NUM_CELLS*ALT_OUTS-1:0] alt = {NUM_CELLS{4'h5}};
  int failures = 0;
  int n_checks = 0;

  always #2 clk = ~clk;

  pin_mux_top dut (.I_MCLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pw),
    .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
    .I_PAD_IN(pin), .O_PAD_OUT(pout), .O_PAD_OE(poe), .O_PAD_PULL_UP(pu), .O_PAD_PULL_DN(pd),
    .I_ALT_OUT(alt), .O_CELL_IN(cin), .I_AUX_SPORT_SLAVE(slv), .O_AUX_SPORT_SELECT(sel),
    .I_AUDIO_DOUT(ded[0]), .I_AUDIO_CLK(ded[1]), .I_AUDIO_SYNC(ded[2]), .O_AUDIO_DIN(adin),
    .I_SHARED_CLOCK_REQUEST(ded[3]), .O_DEVICE_WAKE_IN(dwake), .O_EXT_SLOW_OSC_IN(sosc),
    .I_LOW_POWER(lp), .O_IRQ(irq), .O_SYS_WAKE(swake));

  pad_partner far (.i_clk(clk), .i_pad_out(pout), .i_pad_oe(poe), .i_pull_up(pu),
    .i_pull_dn(pd), .i_ext_val(xv), .i_ext_en(xe), .o_pad_in(pin));

  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // The slave never stalls, but the access phase still repeats until ready is seen.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(negedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #40000;
    failures++;
    conclude();
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    row_t r;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    chk("reset", {sel, poe}, 32'h1000);
    apb(1'b1, A_DOUT_LO, 32'h9);
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, {4'h0, r.c, 2'h0}, 32'(r.cfg));
      wt(2);
      chk("pad", {poe[r.p], pout[r.p], pu[r.p], pd[r.p]}, 32'(r.e));
      apb(1'b0, {4'h0, r.c, 2'h0}, 32'h0);
      chk("cfg", rd, 32'(r.cfg));
      apb(1'b1, {4'h0, r.c, 2'h0}, 32'h0);
    end
    apb(1'b1, 12'h000, 32'h10);
    apb(1'b1, 12'h088, 32'h10);
    wt(2);
    chk("prio", {poe[7], pout[7]}, 32'h3);
    apb(1'b1, A_DOUT_LO, 32'h0);
    apb(1'b1, A_DOUT_HI, 32'h4);
    wt(2);
    chk("prio", {poe[7], pout[7]}, 32'h2);
    @(posedge clk);
    lp <= 1'b1;
    apb(1'b1, A_DOUT_LO, 32'h9);
    wt(2);
    chk("hold", {poe[7], pout[7]}, 32'h2);
    @(posedge clk);
    lp <= 1'b0;
    wt(2);
    chk("hold", {poe[7], pout[7]}, 32'h3);
    apb(1'b1, 12'h088, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h00c, 32'h10);
    apb(1'b1, 12'h010, 32'h10);
    @(posedge clk);
    xe <= 12'h540;
    xv <= 12'h540;
    ded <= 4'h8;
    apb(1'b1, A_DED, 32'h1);
    wt(2);
    chk("aud", {poe[0], pout[0], adin}, 32'h5);
    apb(1'b1, A_EN_HI, 32'h100);
    apb(1'b1, A_DED, 32'h3e);
    wt(2);
    chk("wake", {irq, swake}, 32'h3);
    chk("ded", {poe[0], pout[0], poe[11], pout[11], poe[9], pout[9], dwake, sosc}, 32'hff);
    @(posedge clk);
    xv[8] <= 1'b0;
    wt(1);
    chk("osc", sosc, 32'h0);
    apb(1'b1, A_DED, 32'h0);
    apb(1'b1, A_CLR_HI, 32'h100);
    chk("wclr", irq, 32'h0);
    apb(1'b1, 12'h00c, 32'h0);
    apb(1'b1, 12'h010, 32'h0);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      xv[6] <= st[i];
      apb(1'b1, 12'h030, {21'h0, i[0], md[i], 7'h08});
      apb(1'b1, A_EN_LO, 32'h1000);
      apb(1'b1, A_CLR_LO, 32'h1000);
      chk("quiet", irq, 32'h0);
      @(posedge clk);
      xv[6] <= ~st[i];
      wt(5);
      chk("irq", {irq, swake, cin[12]}, {29'h0, 1'b1, i[0], ~st[i]});
      apb(1'b1, A_EN_LO, 32'h0);
      apb(1'b0, A_STAT_LO, 32'h0);
      chk("mask", {irq, rd[12]}, 32'h1);
    end
    apb(1'b1, 12'h030, 32'h0);
    apb(1'b0, 12'h0a0, 32'h0);
    chk("err", {er, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h09c, 32'h10);
    apb(1'b0, 12'h09c, 32'h0);
    wt(1);
    chk("unbonded", {rd[10:0], poe}, 32'h10000);
    @(posedge clk);
    xv <= 12'h0;
    xe <= 12'h004;
    slv <= 1'b1;
    apb(1'b1, 12'h068, 32'hb);
    wt(4);
    chk("cs", sel, 32'h0);
    @(posedge clk);
    slv <= 1'b0;
    apb(1'b1, 12'h008, 32'h17);
    wt(4);
    chk("cs", {sel, poe[3]}, 32'h3);
    @(posedge clk);
    slv <= 1'b1;
    wt(4);
    chk("dout", {sel, poe[3]}, 32'h0);
    @(posedge clk);
    rst <= 1'b1;
    wt(2);
    @(posedge clk);
    rst <= 1'b0;
    wt(1);
    chk("rst", {sel, poe}, 32'h1000);
    apb(1'b0, 12'h008, 32'h0);
    chk("rst", rd, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire

// >>> testbench/pad_partner.sv
// Purpose: Pads and the outside parties wired to them.
// Assumes: Bench drivers change just after rising edges.
// Notes:   A pad nobody drives and nothing pulls toggles every cycle.
`timescale 1ns/1ps
`default_nettype none
module pad_partner import pinmux_pkg::*; (
  // Clock
  input wire logic i_clk,
  // Device side
  input wire logic [NUM_PADS-1:0] i_pad_out,
  input wire logic [NUM_PADS-1:0] i_pad_oe,
  input wire logic [NUM_PADS-1:0] i_pull_up,
  input wire logic [NUM_PADS-1:0] i_pull_dn,
  // Outside parties
  input wire logic [NUM_PADS-1:0] i_ext_val,
  input wire logic [NUM_PADS-1:0] i_ext_en,
  output logic [NUM_PADS-1:0] o_pad_in
);
  logic [NUM_PADS-1:0] float_q = '0;
  logic [NUM_PADS-1:0] free_w;
  // A floating pad must not read as a steady level, or stale data passes.
  always_ff @(posedge i_clk) begin
    float_q <= ~float_q;
  end
  assign free_w = ~i_pad_oe & ~i_ext_en;
  assign o_pad_in = (i_pad_oe & i_pad_out)
    | (~i_pad_oe & i_ext_en & i_ext_val)
    | (free_w & i_pull_up)
    | (free_w & ~i_pull_up & ~i_pull_dn & float_q);
endmodule
`default_nettype wire
